/* common/omc_consts.svh */
// constants of the optical module control and status block
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH

// system clock rate in kHz (200 MHz)
`define OMC_CLK_KHZ 200000

// least time the disable pin is held to clear a latched fault, in us
`define OMC_T_RESET_US 10
`define OMC_T_RESET_CYC ((`OMC_T_RESET_US * `OMC_CLK_KHZ + 999) / 1000)

// longest power-on times in ms, and longest write cycle time in ms
`define OMC_T_INIT_MS 300
`define OMC_T_SERIAL_MS 300
`define OMC_T_DATA_MS 1000
`define OMC_T_WRITE_MS 10
`define OMC_T_INIT_CYC (`OMC_T_INIT_MS * `OMC_CLK_KHZ)
`define OMC_T_SERIAL_CYC (`OMC_T_SERIAL_MS * `OMC_CLK_KHZ)
`define OMC_T_DATA_CYC (`OMC_T_DATA_MS * `OMC_CLK_KHZ)
`define OMC_T_WRITE_CYC (`OMC_T_WRITE_MS * `OMC_CLK_KHZ)

// two-wire device identifiers: top six bits shared, bit 1 selects the space
`define OMC_DEV_BASE 6'h28
// control/status byte offset in the diagnostic space
`define OMC_CSB_OFS 8'h6e
// control/status byte fields
`define OMC_CSB_HW_DIS 7
`define OMC_CSB_SW_DIS 6
`define OMC_CSB_FAULT 2
`define OMC_CSB_LOS 1
`define OMC_CSB_RDY 0

`endif

/* common/omc_pkg.sv */
// types of the optical module control and status block
`default_nettype none
package omc_pkg;
  // low-speed pins as sampled into the system clock domain
  typedef struct packed {
    logic tx_dis;
    logic fault;
    logic sig_ok;
    logic sda;
    logic scl;
  } omc_pins_t;

  // two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA
  } omc_state_t;
endpackage
`default_nettype wire

/* rtl/omc_ctrl_status.sv */
// control, status and two-wire register logic of an optical transceiver module
`include "omc_consts.svh"
`default_nettype none
// Operation
// - hardware disable high: laser off within 10 us
// - hardware disable low: laser on within 1 ms
// - initialise within 300 ms after power-on
// - fault output asserts within 100 us of fault
// - signal-lost output follows optical input within 100 us
// - software disable bit acts within 100 ms
// - fault status bit set within 100 ms
// - signal-lost status bit updates within 100 ms
// - data-ready bit set within 1000 ms of power-on
// - both address spaces answer within 300 ms
module omc_ctrl_status #(
  parameter logic [27:0] INIT_CYC = 28'(`OMC_T_INIT_CYC),
  parameter logic [27:0] SERIAL_CYC = 28'(`OMC_T_SERIAL_CYC),
  parameter logic [27:0] DATA_CYC = 28'(`OMC_T_DATA_CYC),
  parameter logic [27:0] WRITE_CYC = 28'(`OMC_T_WRITE_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tx_disable_i,
  input wire logic laser_fault_cond_i,
  input wire logic optical_signal_ok_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic laser_on_o,
  output logic tx_fault_o,
  output logic input_signal_lost_o
);
  localparam logic [11:0] RESET_CYC = 12'(`OMC_T_RESET_CYC);
  localparam omc_pkg::omc_pins_t PINS_IDLE = '{sda: 1'b1, scl: 1'b1, default: 1'b0};

  omc_pkg::omc_pins_t raw, sync1, s, d;
  omc_pkg::omc_state_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic ack, next_ack, drv, next_drv, a2, next_a2;
  logic [7:0] shift, next_shift, ptr, next_ptr;
  logic soft_dis, next_soft_dis, soft_pend, next_soft_pend, wr_seen, next_wr_seen;
  logic [27:0] busy, next_busy, por, next_por;
  logic fault, next_fault, next_laser_on, next_tx_fault, next_los;
  logic [11:0] hold, next_hold;
  logic init_done, ser_ready, data_rdy, start, stop, rise, fall;
  logic [7:0] csb, rd_byte;

  assign raw = '{tx_dis: tx_disable_i, fault: laser_fault_cond_i,
                 sig_ok: optical_signal_ok_i, sda: sda_i, scl: scl_i};

  // two-stage synchronisers, reset to idle bus levels to avoid a false edge; d finds edges
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync1 <= PINS_IDLE;
      s <= PINS_IDLE;
      d <= PINS_IDLE;
    end else begin
      sync1 <= raw;
      s <= sync1;
      d <= s;
    end
  end

  // bus conditions, seen on the sampled clock; 100 kHz leaves ample samples
  assign rise = s.scl & ~d.scl;
  assign fall = ~s.scl & d.scl;
  assign start = s.scl & d.scl & d.sda & ~s.sda;
  assign stop = s.scl & d.scl & ~d.sda & s.sda;

  // power-on milestones from one saturating counter
  assign init_done = por >= INIT_CYC;
  assign ser_ready = por >= SERIAL_CYC;
  assign data_rdy = por >= DATA_CYC;

  // control/status byte; only the software disable bit is writable
  always_comb begin
    csb = 8'h00;
    csb[`OMC_CSB_HW_DIS] = s.tx_dis;
    csb[`OMC_CSB_SW_DIS] = soft_dis;
    csb[`OMC_CSB_FAULT] = tx_fault_o;
    csb[`OMC_CSB_LOS] = input_signal_lost_o;
    csb[`OMC_CSB_RDY] = data_rdy;
    rd_byte = (a2 && ptr == `OMC_CSB_OFS) ? csb : 8'h00;
  end

  // next state of laser control, fault latch and bus slave
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_ack = ack;
    next_drv = drv;
    next_a2 = a2;
    next_shift = shift;
    next_ptr = ptr;
    next_soft_dis = soft_dis;
    next_soft_pend = soft_pend;
    next_wr_seen = wr_seen;
    next_busy = (busy != 28'h0) ? busy - 28'h1 : busy;
    next_por = (por >= DATA_CYC) ? por : por + 28'h1;
    // a fault that is present always wins over a clear
    next_fault = fault | s.fault;
    next_hold = s.tx_dis ? ((hold >= RESET_CYC) ? hold : hold + 12'h1) : 12'h0;
    // release after a long enough hold clears the latch
    if (!s.tx_dis && d.tx_dis && hold >= RESET_CYC) begin
      next_fault = s.fault;
    end
    // laser held dark by either disable, a fault or pending init
    next_laser_on = ~(s.tx_dis | soft_dis | fault | ~init_done);
    next_tx_fault = fault;
    next_los = ~s.sig_ok;

    if (start) begin
      next_st = omc_pkg::ST_DEV;
      next_cnt = 4'h0;
      next_ack = 1'b0;
      next_drv = 1'b0;
    end else if (stop) begin
      next_st = omc_pkg::ST_IDLE;
      next_ack = 1'b0;
      next_drv = 1'b0;
      // written disable takes effect at the stop; write cycle runs from here
      if (wr_seen) begin
        next_soft_dis = soft_pend;
        next_busy = WRITE_CYC;
        next_wr_seen = 1'b0;
      end
    end else if (st != omc_pkg::ST_IDLE) begin
      if (rise) begin
        if (ack) begin
          // master nack ends a read
          if (st == omc_pkg::ST_RDATA && s.sda) begin
            next_st = omc_pkg::ST_IDLE;
          end
        end else if (cnt < 4'h8) begin
          next_shift = {shift[6:0], s.sda};
          next_cnt = cnt + 4'h1;
        end
      end else if (fall) begin
        if (ack) begin
          next_ack = 1'b0;
          next_drv = 1'b0;
          next_cnt = 4'h0;
          if (st == omc_pkg::ST_RDATA) begin
            next_shift = rd_byte;
            next_drv = ~rd_byte[7];
            next_ptr = ptr + 8'h1;
          end
        end else if (cnt == 4'h8) begin
          next_ack = 1'b1;
          next_drv = 1'b0;
          unique case (st)
            omc_pkg::ST_DEV: begin
              // no answer before the bus is ready or during a write cycle
              if (shift[7:2] == `OMC_DEV_BASE && ser_ready && busy == 28'h0) begin
                next_drv = 1'b1;
                next_a2 = shift[1];
                next_st = shift[0] ? omc_pkg::ST_RDATA : omc_pkg::ST_ADDR;
              end else begin
                next_st = omc_pkg::ST_IDLE;
                next_ack = 1'b0;
              end
            end
            omc_pkg::ST_ADDR: begin
              next_drv = 1'b1;
              next_ptr = shift;
              next_st = omc_pkg::ST_WDATA;
            end
            omc_pkg::ST_WDATA: begin
              // writes elsewhere are acknowledged and dropped
              next_drv = 1'b1;
              next_ptr = ptr + 8'h1;
              if (a2 && ptr == `OMC_CSB_OFS) begin
                next_soft_pend = shift[`OMC_CSB_SW_DIS];
                next_wr_seen = 1'b1;
              end
            end
            omc_pkg::ST_RDATA: next_drv = 1'b0;
            omc_pkg::ST_IDLE: next_drv = 1'b0;
          endcase
        end else if (st == omc_pkg::ST_RDATA) begin
          // the shift moves the next read bit into the top position
          next_drv = ~shift[7];
        end
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= omc_pkg::ST_IDLE;
      cnt <= 4'h0;
      ack <= 1'b0;
      drv <= 1'b0;
      a2 <= 1'b0;
      shift <= 8'h00;
      ptr <= 8'h00;
      soft_dis <= 1'b0;
      soft_pend <= 1'b0;
      wr_seen <= 1'b0;
      busy <= 28'h0;
      por <= 28'h0;
      fault <= 1'b0;
      hold <= 12'h0;
      laser_on_o <= 1'b0;
      tx_fault_o <= 1'b0;
      input_signal_lost_o <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      ack <= next_ack;
      drv <= next_drv;
      a2 <= next_a2;
      shift <= next_shift;
      ptr <= next_ptr;
      soft_dis <= next_soft_dis;
      soft_pend <= next_soft_pend;
      wr_seen <= next_wr_seen;
      busy <= next_busy;
      por <= next_por;
      fault <= next_fault;
      hold <= next_hold;
      laser_on_o <= next_laser_on;
      tx_fault_o <= next_tx_fault;
      input_signal_lost_o <= next_los;
    end
  end

  // open-drain data line: only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_o = drv;

  property p_hw_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s.tx_dis |=> !laser_on_o;
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("laser on with pin disable");
  property p_hw_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ($fell(s.tx_dis) && !soft_dis && !fault && init_done) |=> laser_on_o;
  endproperty
  a_hw_on: assert property (p_hw_on) else $error("laser not back after release");
  property p_init;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!init_done |=> !laser_on_o) and
      ((por == INIT_CYC && !s.tx_dis && !soft_dis && !fault) |=> laser_on_o);
  endproperty
  a_init: assert property (p_init) else $error("laser state wrong around init");
  property p_fault;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s.fault |=> ##1 tx_fault_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault output late");
  property p_fault_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ($fell(s.tx_dis) && hold < RESET_CYC && fault) |=> fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared by short pulse");
  property p_los;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> input_signal_lost_o == !$past(s.sig_ok) &&
        csb[`OMC_CSB_LOS] == input_signal_lost_o;
  endproperty
  a_los: assert property (p_los) else $error("signal lost output wrong");
  property p_soft;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (stop && wr_seen) |=> (soft_dis == $past(soft_pend)) ##1
        ($past(s.tx_dis) || $past(fault) || !$past(init_done) ||
         laser_on_o == !$past(soft_dis));
  endproperty
  a_soft: assert property (p_soft) else $error("software disable not applied");
  property p_rdy;
    @(posedge clk_sys_i) disable iff (!rst_n_i) csb[`OMC_CSB_RDY] == (por >= DATA_CYC);
  endproperty
  a_rdy: assert property (p_rdy) else $error("data ready flag wrong");
  property p_ser;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == omc_pkg::ST_DEV && fall && !ack && cnt == 4'h8 && !ser_ready) |=> !sda_oe_o;
  endproperty
  a_ser: assert property (p_ser) else $error("answered before bus ready");
  property p_busy;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (stop && wr_seen) |=> busy == WRITE_CYC ##1 busy == WRITE_CYC - 28'h1;
  endproperty
  a_busy: assert property (p_busy) else $error("write cycle timer wrong");
  property p_dis;
    @(posedge clk_sys_i) disable iff (!rst_n_i) (s.tx_dis || soft_dis) |=> !laser_on_o;
  endproperty
  a_dis: assert property (p_dis) else $error("laser on while disabled");
endmodule
`default_nettype wire

/* verif/omc_host_model.sv */
// host controller model: two-wire bus master with open-drain data line
`default_nettype none
module omc_host_model (
  input wire logic sda_oe_i,
  input wire logic sda_drv_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low;
  // wired-and with pull-up: a released line reads high, never a stale value
  assign sda_o = (host_low || (sda_oe_i && !sda_drv_i)) ? 1'b0 : 1'b1;
  // bus idles with both lines high; the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    host_low = 1'b0;
  end
  // one bit per 48 ns: data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #12 host_low = !b;
    #12 scl_o = 1'b1;
    #12 r = sda_o;
    #12 scl_o = 1'b0;
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    #12 host_low = 1'b0;
    #12 scl_o = 1'b1;
    #12 host_low = 1'b1;
    #12 scl_o = 1'b0;
  endtask
  // stop: data rises while the clock is high, then the bus rests
  task automatic stop();
    #12 host_low = 1'b1;
    #12 scl_o = 1'b1;
    #12 host_low = 1'b0;
    #12;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule
`default_nettype wire

/* verif/test_omc_ctrl_status.sv */
// self-checking bench of the optical module control and status block
`default_nettype none
module test_omc_ctrl_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tx_dis = 1'b0;
  logic fault_cond = 1'b0;
  logic sig_ok = 1'b1;
  logic scl, sda, sda_drv, sda_oe, laser_on, tx_fault, sig_lost, ack;
  logic [7:0] rd_val;
  logic [7:0] junk;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  // rows: pin disable, fault, signal ok, then laser on, fault out, signal lost
  localparam logic [5:0] ROWS [4] = '{6'b001_100, 6'b101_000, 6'b000_101, 6'b001_100};

  omc_ctrl_status #(.INIT_CYC(28'h00000c8), .SERIAL_CYC(28'h000012c),
    .DATA_CYC(28'h00007d0), .WRITE_CYC(28'h0000190)) DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tx_disable_i(tx_dis),
    .laser_fault_cond_i(fault_cond), .optical_signal_ok_i(sig_ok), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe), .laser_on_o(laser_on),
    .tx_fault_o(tx_fault), .input_signal_lost_o(sig_lost));
  omc_host_model host (.sda_oe_i(sda_oe), .sda_drv_i(sda_drv), .scl_o(scl), .sda_o(sda));

  // clock, and a cycle ceiling well above the expected run length
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // set the three pins, then let the synchronisers and outputs settle
  task automatic pins(input logic [2:0] p);
    @(posedge clk_sys_i);
    {tx_dis, fault_cond, sig_ok} <= p;
    repeat (5) @(posedge clk_sys_i);
    #1;
  endtask

  // address only, to see whether the device answers
  task automatic probe(input logic [7:0] id, output logic a);
    host.start();
    host.xfer(id, 1'b1, junk, a);
    host.stop();
  endtask

  task automatic wr(input logic [7:0] id, input logic [7:0] ofs, input logic [7:0] d,
                    output logic a);
    logic a2;
    host.start();
    host.xfer(id, 1'b1, junk, a);
    host.xfer(ofs, 1'b1, junk, a2);
    host.xfer(d, 1'b1, junk, a2);
    host.stop();
  endtask

  // random read: offset write, repeated start, one byte ended by a nack
  task automatic rd(input logic [7:0] id, input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    host.start();
    host.xfer(id, 1'b1, junk, a);
    host.xfer(ofs, 1'b1, junk, a);
    host.start();
    host.xfer(id | 8'h01, 1'b1, junk, a);
    host.xfer(8'hff, 1'b1, d, a);
    host.stop();
  endtask

  // main sequence: power-on, register reads and other-space write, pin table, then register and fault cases
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1 check({4'h0, sda_oe, laser_on, tx_fault, sig_lost}, 8'h01);
    @(posedge clk_sys_i) rst_n_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    probe(8'ha2, ack);
    check({7'h00, ack}, 8'h01);
    check({7'h00, laser_on}, 8'h00);
    repeat (100) @(posedge clk_sys_i);
    #1 check({7'h00, laser_on}, 8'h01);
    repeat (120) @(posedge clk_sys_i);
    rd(8'ha2, 8'h6e, rd_val);
    check(rd_val, 8'h00);
    rd(8'ha0, 8'h6e, rd_val);
    check(rd_val, 8'h00);
    // other space: acknowledged and dropped, no write cycle, laser stays on in row 0
    wr(8'ha0, 8'h6e, 8'h40, ack);
    check({7'h00, ack}, 8'h00);
    probe(8'ha2, ack);
    check({7'h00, ack}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pins(ROWS[i][5:3]);
      check({5'h00, laser_on, tx_fault, sig_lost}, {5'h00, ROWS[i][2:0]});
    end
    while (cyc < 2100) @(posedge clk_sys_i);
    wr(8'ha2, 8'h6e, 8'h40, ack);
    check({7'h00, ack}, 8'h00);
    probe(8'ha2, ack);
    check({6'h00, ack, laser_on}, 8'h02);
    repeat (400) @(posedge clk_sys_i); // write cycle waited out
    pins(3'b000);
    rd(8'ha2, 8'h6e, rd_val);
    check(rd_val, 8'h43);
    pins(3'b001);
    wr(8'ha2, 8'h6e, 8'h00, ack);
    pins(3'b001);
    check({7'h00, laser_on}, 8'h01);
    repeat (400) @(posedge clk_sys_i); // write cycle waited out
    pins(3'b011);
    check({6'h00, laser_on, tx_fault}, 8'h01);
    pins(3'b001);
    rd(8'ha2, 8'h6e, rd_val);
    check(rd_val, 8'h05);
    pins(3'b101);
    repeat (100) @(posedge clk_sys_i); // too short to clear the latch
    pins(3'b001);
    check({7'h00, tx_fault}, 8'h01);
    pins(3'b101);
    repeat (2100) @(posedge clk_sys_i); // held past the clearing time
    pins(3'b001);
    check({6'h00, laser_on, tx_fault}, 8'h02);
    complete_run();
  end
endmodule
`default_nettype wire
